//--- shared/uad_pkg.sv
/*
  Shared definitions for the alpha field decoder: scheme codes,
  fill value, octet positions and the carrier structs.
  Assumes a single clock domain; no registers reachable by software.
*/
package uad_pkg;

  // ----------------------------------------------------------------
  // Scheme codes carried in the leading octet
  // ----------------------------------------------------------------
  localparam logic [7:0] SCHEME_PLAIN16 = 8'h80;
  localparam logic [7:0] SCHEME_HALF8   = 8'h81;
  localparam logic [7:0] SCHEME_HALF16  = 8'h82;
  localparam logic [7:0] FILL_OCTET     = 8'hff;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          EXT_BIT       = 7;    // Octet bit 8
  localparam int          BASE_HI_LSB   = 7;    // Octet 3 lands at 14:7
  localparam logic [15:0] BASE_HI_MASK  = 16'h7f80;
  localparam logic [7:0]  COUNT_RESET   = 8'h00;
  localparam logic [15:0] BASE_RESET    = 16'h0000;

  // Output character classes
  typedef enum logic [1:0]
  {
    UAD_KIND_DEFAULT = 2'h0,  // 7-bit default alphabet
    UAD_KIND_UCS2    = 2'h1   // 16-bit code point
  } uad_kind_e;

  // Octet coming in from the record store
  typedef struct packed
  {
    logic       first;  // Leading octet of a field
    logic       last;   // Final octet of a field
    logic [7:0] data;
  } uad_octet_s;

  // Decoded character going out
  typedef struct packed
  {
    uad_kind_e   kind;
    logic [15:0] code;
    logic        last;  // Final character of the field
  } uad_char_s;

endpackage

//--- design/uad_half_page.sv
/*
  Half-page expander: maps one compressed octet to a character.
  Assumes the base pointer is stable while octets are expanded.
*/
`timescale 1ns/10ps
module uad_half_page
(
  // Inputs
  input  wire logic [7:0]       octet,
  input  wire logic [15:0]      base,
  // Result
  output uad_pkg::uad_char_s    chr
);

  // Clear top bit: default alphabet; set: base plus offset
  always_comb
  begin
    chr.last = 1'b0;
    if (octet[uad_pkg::EXT_BIT])
    begin
      chr.kind = uad_pkg::UAD_KIND_UCS2;
      chr.code = base + {9'h000, octet[6:0]};
    end
    else
    begin
      chr.kind = uad_pkg::UAD_KIND_DEFAULT;
      chr.code = {9'h000, octet[6:0]};
    end
  end

endmodule

//--- design/uad_decoder.sv
/*
  Alpha field decoder: turns the octets of one stored text field into
  characters, 16-bit code points or 7-bit default alphabet values.
  Assumes octets arrive in order, one per accepted cycle, framed by
  first/last flags, and that the consumer may stall with out_ready.
*/
`timescale 1ns/10ps
// Contract
// - '80' pairs octets, upper byte first
// - unpaired trailing 'FF' octet is not decoded
// - '81' gives count, base from octet 3
// - '81' octets: default char or base+offset
// - '82' gives count, 16-bit base octets 3-4
// - '82' octets from fifth: default or base+offset
// - all three schemes supported, any set size
module uad_decoder
(
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               clk_en,
  // Octet stream in
  input  wire logic               in_valid,
  output logic                    in_ready,
  input  wire uad_pkg::uad_octet_s in_octet,
  // Character stream out
  output logic                    out_valid,
  input  wire logic               out_ready,
  output uad_pkg::uad_char_s      out_char
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [6:0]
  {
    ST_IDLE  = 7'h01,  // Waiting for leading octet
    ST_PLAIN = 7'h02,  // Default alphabet pass-through
    ST_UPPER = 7'h04,  // '80': expecting upper_char_byte
    ST_LOWER = 7'h08,  // '80': expecting lower_char_byte
    ST_COUNT = 7'h10,  // '81'/'82': count octet
    ST_BASE  = 7'h20,  // Base pointer octet(s)
    ST_HALF  = 7'h40   // Compressed characters
  } uad_state_e;

  uad_state_e  state;
  logic        wide_base;   // '82' scheme, two base octets
  logic        base_lo;     // Second base octet pending
  logic [7:0]  remaining;
  logic [7:0]  upper_char_byte;
  logic [15:0] base;
  logic        take;
  logic        emit;
  uad_pkg::uad_char_s next_char;
  uad_pkg::uad_char_s half_char;

  // Out register must be free before an octet that may emit is taken
  assign in_ready = clk_en && (!out_valid || out_ready);
  assign take     = in_valid && in_ready;

  uad_half_page u_half
  (
    .octet (in_octet.data),
    .base  (base),
    .chr   (half_char)
  );

  // ----------------------------------------------------------------
  // Character selection
  // ----------------------------------------------------------------
  // Decide whether the accepted octet produces a character
  always_comb
  begin
    emit      = 1'b0;
    next_char = '0;
    unique case (state)
      ST_IDLE:
      begin
        // Unknown leading code is itself a default character
        if (in_octet.data != uad_pkg::SCHEME_PLAIN16 &&
            in_octet.data != uad_pkg::SCHEME_HALF8 &&
            in_octet.data != uad_pkg::SCHEME_HALF16)
        begin
          emit           = 1'b1;
          next_char.kind = uad_pkg::UAD_KIND_DEFAULT;
          next_char.code = {9'h000, in_octet.data[6:0]};
          next_char.last = in_octet.last;
        end
      end
      ST_PLAIN:
      begin
        emit           = 1'b1;
        next_char.kind = uad_pkg::UAD_KIND_DEFAULT;
        next_char.code = {9'h000, in_octet.data[6:0]};
        next_char.last = in_octet.last;
      end
      ST_LOWER:
      begin
        // Fill pair marks unused space and is dropped
        emit = !(upper_char_byte == uad_pkg::FILL_OCTET &&
                 in_octet.data == uad_pkg::FILL_OCTET);
        next_char.kind = uad_pkg::UAD_KIND_UCS2;
        next_char.code = {upper_char_byte, in_octet.data};
        next_char.last = in_octet.last;
      end
      ST_HALF:
      begin
        emit           = remaining != 8'h00;
        next_char      = half_char;
        next_char.last = remaining == 8'h01 || in_octet.last;
      end
      ST_UPPER, ST_COUNT, ST_BASE:
      begin
        emit = 1'b0;  // Upper byte held for its pair; count and base octets give no character
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  // Scheme walk; a last octet always returns to idle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      state <= ST_IDLE;
    else if (take)
    begin
      if (in_octet.last)
        state <= ST_IDLE;
      else
        unique case (state)
          ST_IDLE:
            if (in_octet.data == uad_pkg::SCHEME_PLAIN16)
              state <= ST_UPPER;
            else if (in_octet.data == uad_pkg::SCHEME_HALF8 ||
                     in_octet.data == uad_pkg::SCHEME_HALF16)
              state <= ST_COUNT;
            else
              state <= ST_PLAIN;
          ST_PLAIN: state <= ST_PLAIN;
          ST_UPPER: state <= ST_LOWER;
          ST_LOWER: state <= ST_UPPER;
          ST_COUNT: state <= ST_BASE;
          ST_BASE:  state <= (wide_base && !base_lo) ? ST_BASE : ST_HALF;
          ST_HALF:  state <= ST_HALF;
        endcase
    end
  end

  // Scheme flags, count and base pointer capture
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wide_base <= 1'b0;
      base_lo   <= 1'b0;
      remaining <= uad_pkg::COUNT_RESET;
      base      <= uad_pkg::BASE_RESET;
    end
    else if (take)
    begin
      unique case (state)
        ST_IDLE:
        begin
          wide_base <= in_octet.data == uad_pkg::SCHEME_HALF16;
          base_lo   <= 1'b0;
        end
        ST_COUNT: remaining <= in_octet.data;
        ST_BASE:
        begin
          if (!wide_base)
            base <= {1'b0, in_octet.data, 7'h00}
                    & uad_pkg::BASE_HI_MASK;
          else if (!base_lo)
          begin
            base[15:8] <= in_octet.data;
            base_lo    <= 1'b1;
          end
          else
            base[7:0]  <= in_octet.data;
        end
        ST_HALF:
          if (remaining != 8'h00)
            remaining <= remaining - 8'h01;
        default: ;
      endcase
    end
  end

  // Upper byte of a '80' pair held until the lower arrives
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      upper_char_byte <= 8'h00;
    else if (take && state == ST_UPPER)
      upper_char_byte <= in_octet.data;
  end

  // ----------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------
  // Data from flip-flops; valid holds until the consumer takes it
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_char  <= '0;
    end
    else if (clk_en)
    begin
      if (take && emit)
      begin
        out_valid <= 1'b1;
        out_char  <= next_char;
      end
      else if (out_ready)
        out_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  pair_order_a: assert property (@(posedge ref_clk) disable iff (rst)
    take && state == ST_LOWER && emit |=> out_valid &&
    out_char.code == {$past(upper_char_byte), $past(in_octet.data)})
    else $error("pair not joined upper first");

  fill_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
    take && state == ST_UPPER |=> !out_valid || $stable(out_char))
    else $error("unpaired octet produced a character");

  base_half_a: assert property (@(posedge ref_clk) disable iff (rst)
    state == ST_HALF && !wide_base |-> base[15] == 1'b0 && base[6:0] == 7'h00)
    else $error("half page base has forced bits set");

  count_load_a: assert property (@(posedge ref_clk) disable iff (rst)
    take && state == ST_COUNT && !in_octet.last |=> remaining == $past(in_octet.data))
    else $error("count not captured");

  half_map_a: assert property (@(posedge ref_clk) disable iff (rst)
    take && state == ST_HALF && remaining != 8'h00 && in_octet.data[7] |=>
    out_char.kind == uad_pkg::UAD_KIND_UCS2 &&
    out_char.code == $past(base) + {9'h000, $past(in_octet.data[6:0])})
    else $error("offset character mis-mapped");

  half_default_a: assert property (@(posedge ref_clk) disable iff (rst)
    take && state == ST_HALF && remaining != 8'h00 && !in_octet.data[7] |=>
    out_char.kind == uad_pkg::UAD_KIND_DEFAULT &&
    out_char.code == {9'h000, $past(in_octet.data[6:0])})
    else $error("default character mis-classed");

  plain_pass_a: assert property (@(posedge ref_clk) disable iff (rst)
    take && state == ST_PLAIN |=> out_valid &&
    out_char.kind == uad_pkg::UAD_KIND_DEFAULT &&
    out_char.code == {9'h000, $past(in_octet.data[6:0])})
    else $error("plain text not passed");

  count_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
    state == ST_HALF && remaining == 8'h00 && take |=> !out_valid || $stable(out_char))
    else $error("character beyond count");

  hold_out_a: assert property (@(posedge ref_clk) disable iff (rst)
    out_valid && !out_ready |=> out_valid && $stable(out_char))
    else $error("output dropped under stall");

  c_plain16_c: cover property (@(posedge ref_clk) disable iff (rst)
    take && state == ST_LOWER && emit);
  c_half8_c: cover property (@(posedge ref_clk) disable iff (rst)
    take && state == ST_HALF && !wide_base && remaining == 8'h01);
  c_half16_c: cover property (@(posedge ref_clk) disable iff (rst)
    take && state == ST_HALF && wide_base);
  c_stall_c: cover property (@(posedge ref_clk) disable iff (rst)
    out_valid && !out_ready);

endmodule

//--- bench/uad_store_model.sv
/*
  Record store model: offers the octets of stored text fields in order,
  one field at a time, promptly or with idle cycles between octets.
  Assumes the decoder takes an octet on a rising edge with in_ready high.
*/
`timescale 1ns/10ps
module uad_store_model
(
  // Clock
  input  wire logic           ref_clk,
  // Octet stream toward the decoder
  output logic                in_valid,
  input  wire logic           in_ready,
  output uad_pkg::uad_octet_s in_octet
);
  // --------------------------------------------------------------
  // Field playback
  // --------------------------------------------------------------
  // Idle bus at time zero
  initial
  begin
    in_valid = 1'b0;
    in_octet = '0;
  end

  // Caller supplies one whole field in a single scheme, fills included
  task automatic play(input logic [7:0] f[$], input int gap);
    for (int i = 0; i < f.size(); i++)
    begin
      repeat (gap) @(posedge ref_clk);
      #1;
      in_valid = 1'b1;
      in_octet = '{first: i == 0, last: i == f.size() - 1, data: f[i]};
      do @(posedge ref_clk); while (!in_ready);
      // Released bus shows inverted data so a stale octet cannot match
      if (gap > 0 || i == f.size() - 1)
      begin
        #1;
        in_valid = 1'b0;
        in_octet = ~in_octet;
      end
    end
  endtask
endmodule

//--- bench/testbench.sv
/*
  Self-checking bench for the alpha field decoder: feeds fields of every
  scheme from the store model and checks the characters that come out.
  Assumes the shared package and the design files are compiled first.
*/
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("ERROR %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module testbench;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic                ref_clk     = 1'b0;
  logic                rst         = 1'b1;
  logic                clk_en      = 1'b1;
  logic                out_ready   = 1'b1;
  logic                stall       = 1'b0;
  logic                in_valid;
  logic                in_ready;
  logic                out_valid;
  uad_pkg::uad_octet_s in_octet;
  uad_pkg::uad_char_s  out_char;
  uad_pkg::uad_char_s  got_q[$];
  uad_pkg::uad_char_s  exp_q[$];
  int                  err_total   = 0;
  int                  check_count = 0;

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  // Consumer toggles ready while stalling, so outputs must hold
  always @(posedge ref_clk) out_ready <= #1 stall ? ~out_ready : 1'b1;

  // Capture each character the consumer accepts
  always @(posedge ref_clk)
    if (!rst && clk_en && out_valid && out_ready) got_q.push_back(out_char);

  // --------------------------------------------------------------
  // Design and partner
  // --------------------------------------------------------------
  uad_decoder uad_decoder_inst (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .in_valid(in_valid), .in_ready(in_ready), .in_octet(in_octet),
    .out_valid(out_valid), .out_ready(out_ready), .out_char(out_char));
  uad_store_model uad_store_model_inst (.ref_clk(ref_clk), .in_valid(in_valid),
    .in_ready(in_ready), .in_octet(in_octet));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic uad_pkg::uad_char_s ch(input logic [15:0] c, input bit u, input bit l);
    ch = '{kind: u ? uad_pkg::UAD_KIND_UCS2 : uad_pkg::UAD_KIND_DEFAULT, code: c, last: l};
  endfunction

  // Bounded wait, then idle cycles so surplus characters show up too
  task automatic check_chars(input string name, input int dc_idx);
    int n;
    n = 0;
    while (got_q.size() < exp_q.size() && n < 200)
    begin
      @(posedge ref_clk);
      n++;
    end
    repeat (8) @(posedge ref_clk);
    `CHK(got_q.size(), exp_q.size())
    foreach (exp_q[i])
    begin
      if (i < got_q.size())
      begin
        `CHK(got_q[i].kind, exp_q[i].kind)
        `CHK(got_q[i].code, exp_q[i].code)
        // End mark of the character before a dropped fill pair is left to the design
        if (i != dc_idx) `CHK(got_q[i].last, exp_q[i].last)
      end
    end
    got_q.delete();
    exp_q.delete();
    $display("Test %s finished", name);
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  // Plain 16-bit scheme: fill pair and unpaired fill give nothing
  task automatic t_plain16();
    uad_store_model_inst.play('{8'h80, 8'h00, 8'h41, 8'hff, 8'hff, 8'hff}, 0);
    uad_store_model_inst.play('{8'h80, 8'h12, 8'h34}, 0);
    exp_q = '{ch(16'h0041, 1, 0), ch(16'h1234, 1, 1)};
    check_chars("plain16", 0);
  endtask

  // Half page from one octet, slow store and stalling consumer
  task automatic t_half8();
    stall = 1'b1;
    uad_store_model_inst.play('{8'h81, 8'h05, 8'h13, 8'h53, 8'h95, 8'ha6, 8'h20,
                                8'hff, 8'hff}, 2);
    uad_store_model_inst.play('{8'h81, 8'h01, 8'hff, 8'h85, 8'h86}, 0);
    exp_q = '{ch(16'h0053, 0, 0), ch(16'h0995, 1, 0), ch(16'h09a6, 1, 0),
              ch(16'h0020, 0, 0), ch(16'h09ff, 1, 1), ch(16'h7f85, 1, 1)};
    check_chars("half8", -1);
    stall = 1'b0;
  endtask

  // Half page from a full 16-bit base, surplus octet ignored
  task automatic t_half16();
    uad_store_model_inst.play('{8'h82, 8'h05, 8'h05, 8'h30, 8'h2d, 8'h82, 8'hd3,
                                8'h2d, 8'h31, 8'h85}, 0);
    exp_q = '{ch(16'h002d, 0, 0), ch(16'h0532, 1, 0), ch(16'h0583, 1, 0),
              ch(16'h002d, 0, 0), ch(16'h0031, 0, 1)};
    check_chars("half16", -1);
  endtask

  // Default text, with the clock enable dropped mid-field
  task automatic t_default();
    fork
      begin
        uad_store_model_inst.play('{8'hc8, 8'h69}, 0);
        uad_store_model_inst.play('{8'h48, 8'h69}, 0);
      end
      begin
        @(posedge ref_clk);
        #1;
        clk_en = 1'b0;
        #1;
        `CHK(in_ready, 1'b0)
        repeat (3) @(posedge ref_clk);
        #1;
        clk_en = 1'b1;
      end
    join
    exp_q = '{ch(16'h0048, 0, 0), ch(16'h0069, 0, 1), ch(16'h0048, 0, 0),
              ch(16'h0069, 0, 1)};
    check_chars("default", -1);
  endtask

  // --------------------------------------------------------------
  // Run control
  // --------------------------------------------------------------
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Main sequence after three cycles of reset
  initial
  begin
    repeat (3) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    t_plain16();
    t_half8();
    t_half16();
    t_default();
    summarize();
  end

  // Watchdog: the tests need well under a thousand cycles
  initial
  begin
    #20000;
    err_total++;
    $display("ERROR %0t: watchdog expired", $time);
    summarize();
  end
endmodule
